// file: core/ecvs_pkg.sv
// shared constants and types of the embedded-clock video link
package ecvs_pkg;
  localparam int CLK_NS       = 25;
  localparam int CLK_MHZ      = 40;
  localparam int PIX_W        = 18;
  localparam int CTL_W        = 3;
  localparam int TYP_W        = 2;
  localparam int PAY_W        = TYP_W + PIX_W;
  localparam int FRAME_LEN    = PAY_W + 2;
  localparam logic [TYP_W-1:0] TYP_PIX  = 2'h2;
  localparam logic [TYP_W-1:0] TYP_CTL  = 2'h1;
  localparam logic [TYP_W-1:0] TYP_TRN  = 2'h0;
  localparam logic [PIX_W-1:0] TRN_DATA = 18'h2AAAA;
  // slowest pixel period sets the longest legal gap between frames
  localparam int T_PIX_MAX_NS = 200;
  localparam int GAP_CYC      = T_PIX_MAX_NS / CLK_NS;
  localparam int INT_MAX      = FRAME_LEN + GAP_CYC;
  localparam int T_STOP_NS    = 7;
  localparam int STOP_CYC     = (T_STOP_NS / CLK_NS < 1) ? 1 : T_STOP_NS / CLK_NS;
  localparam int T_LOCK_MS    = 10;
  localparam int LOCK_CYC     = T_LOCK_MS * 1000 * CLK_MHZ;
  localparam int TRAIN_TAIL   = 1026;
  localparam int TAIL_W       = 11;
  localparam int LEAD_CYC     = 10;
  localparam int TAIL_CYC     = 3;
  localparam int OUT_DLY      = 2;
  localparam int LOCK_FRAMES  = 4;
  localparam int CNT_W        = 6;
  localparam int EV_W         = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_RATE = 4'h8;
  localparam int CB_TX_EDGE   = 0;
  localparam int CB_RX_EDGE   = 1;
  localparam int CB_TRAIN     = 2;
  localparam logic [2:0] CTRL_RST = 3'h1;
  typedef enum logic [4:0] {
    ST_OFF  = 5'h01,
    ST_HUNT = 5'h02,
    ST_LEAD = 5'h04,
    ST_LOCK = 5'h08,
    ST_TAIL = 5'h10
  } ecvs_rx_st_t;
endpackage

// file: core/ecvs_tx_if.sv
// signals between the core and the serializer
`timescale 1ns/1ps
interface ecvs_tx_if;
  import ecvs_pkg::*;
  logic             pclk_rise;
  logic             pclk_fall;
  logic             edge_rising;
  logic [PIX_W-1:0] pixel_bits;
  logic [CTL_W-1:0] control_bits;
  logic             pixel_valid;
  logic             train;
  logic             sleep_n;
  logic             serial_out;
  logic             serial_oe_n;
  logic             training;
  modport tx (input pclk_rise, pclk_fall, edge_rising, pixel_bits, control_bits,
              pixel_valid, train, sleep_n, output serial_out, serial_oe_n, training);
  modport core (output pclk_rise, pclk_fall, edge_rising, pixel_bits, control_bits,
                pixel_valid, train, sleep_n, input serial_out, serial_oe_n, training);
endinterface

// file: core/ecvs_sync.sv
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module ecvs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  // level in and out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// file: core/ecvs_tx.sv
// serializer: captures words on the pixel clock and sends framed bits
`timescale 1ns/1ps
module ecvs_tx (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // core side
  ecvs_tx_if.tx     t
);
  import ecvs_pkg::*;
  logic [PAY_W-1:0]     word_r;
  logic [PAY_W-1:0]     word_nxt;
  logic                 pend_r;
  logic                 busy_r;
  logic                 oe_n_r;
  logic [FRAME_LEN-1:0] sh_r;
  logic [4:0]           bit_r;
  logic [TAIL_W-1:0]    tail_r;
  logic                 cap;
  logic                 load;

  assign cap           = t.edge_rising ? t.pclk_rise : t.pclk_fall;
  assign t.training    = t.sleep_n & (t.train | (tail_r != '0));
  assign load          = !busy_r && (pend_r || t.training);
  assign t.serial_out  = sh_r[FRAME_LEN-1];
  assign t.serial_oe_n = oe_n_r;

  always_comb begin
    if (t.pixel_valid) begin
      word_nxt = {TYP_PIX, t.pixel_bits};
    end else begin
      word_nxt = {TYP_CTL, {(PIX_W-CTL_W){1'b0}}, t.control_bits};
    end
  end

  // training continues for a fixed number of pixel clocks after release
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tail_r <= '0;
    end else if (!t.sleep_n) begin
      tail_r <= '0;
    end else if (t.train) begin
      tail_r <= TAIL_W'(TRAIN_TAIL);
    end else if (cap && tail_r != '0) begin
      tail_r <= tail_r - 1'b1;
    end
  end

  // capture holding word; a new capture wins over the load
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      word_r <= '0;
      pend_r <= 1'b0;
    end else if (!t.sleep_n) begin
      pend_r <= 1'b0;
    end else if (cap) begin
      word_r <= word_nxt;
      pend_r <= 1'b1;
    end else if (load) begin
      pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      oe_n_r <= 1'b1;
      busy_r <= 1'b0;
      bit_r  <= '0;
      sh_r   <= '1;
    end else if (!t.sleep_n) begin
      oe_n_r <= 1'b1;
      busy_r <= 1'b0;
      bit_r  <= '0;
      sh_r   <= '1;
    end else begin
      oe_n_r <= 1'b0;
      if (load) begin
        busy_r <= 1'b1;
        bit_r  <= '0;
        sh_r   <= t.training ? {1'b0, TYP_TRN, TRN_DATA, 1'b1} : {1'b0, word_r, 1'b1};
      end else if (busy_r) begin
        sh_r  <= {sh_r[FRAME_LEN-2:0], 1'b1};
        bit_r <= bit_r + 1'b1;
        if (bit_r == 5'(FRAME_LEN - 1)) begin
          busy_r <= 1'b0;
        end
      end
    end
  end

  a_sleep_hiz: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !t.sleep_n |=> t.serial_oe_n && t.serial_out) else $error("output not released");
  a_train_reload: assert property (@(posedge clk_sys) disable iff (sys_rst)
    t.sleep_n && t.train |=> tail_r == TAIL_W'(TRAIN_TAIL) && t.training)
    else $error("tail");
  a_train_end: assert property (@(posedge clk_sys) disable iff (sys_rst)
    t.sleep_n && !t.train && cap && tail_r == 11'h001 |=> !t.training)
    else $error("training tail did not end");
  a_type_pick: assert property (@(posedge clk_sys) disable iff (sys_rst)
    t.sleep_n && cap |=> word_r[PAY_W-1 -: TYP_W] == ($past(t.pixel_valid) ? TYP_PIX : TYP_CTL))
    else $error("wrong word type");
endmodule

// file: core/ecvs_top.sv
// embedded-clock video link: serializer, clock-recovering receiver, registers
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - receiver locks to 5-40 MHz without reference
// - outputs valid two recovered clocks after lock
// - recovered clock runs ten cycles before lock
// - recovered clock runs three cycles after unlock
// - lock achieved within ten milliseconds
// - data stop drives lock indicator to unlocked
// - valid high sends pixels, low sends controls
// - receiver outputs pixel or control by type
// - normal and handshake training modes exist
// - unlocked indicator drives transmitter training input
// - handshake mode follows from the wiring alone
// - transmitter sleep releases both serial legs
// - edge select picks capture edge
// - training input high sends training pattern
// - receiver sleep: data outputs low, indicator high, recovered clock held at the receive edge-select level
// - training continues 1026 clocks after release
module ecvs_top #(
  parameter int LOCK_LIMIT = ecvs_pkg::LOCK_CYC
) (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      sys_rst,
  // register bus
  input  wire logic [3:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  // transmitter pins
  input  wire logic                      tx_pixel_clk,
  input  wire logic [ecvs_pkg::PIX_W-1:0] tx_pixel_bits,
  input  wire logic [ecvs_pkg::CTL_W-1:0] tx_control_bits,
  input  wire logic                      tx_pixel_valid,
  input  wire logic                      tx_train,
  input  wire logic                      tx_sleep_n,
  output logic                           serial_out,
  output logic                           serial_out_oe_n,
  // receiver pins
  input  wire logic                      serial_in,
  input  wire logic                      rx_sleep_n,
  output logic      [ecvs_pkg::PIX_W-1:0] rx_pixel_bits,
  output logic      [ecvs_pkg::CTL_W-1:0] rx_control_bits,
  output logic                           rx_pixel_valid,
  output logic                           rx_unlocked,
  output logic                           recovered_clock
);
  import ecvs_pkg::*;
  localparam int HW = $clog2(LOCK_LIMIT + 1);

  ecvs_tx_if t ();
  logic [PIX_W+CTL_W+3:0] tx_s;
  logic [1:0]             rx_s;
  logic                   pck_d_r;
  logic [2:0]             ctrl_r;
  logic                   ack_r;
  ecvs_rx_st_t            st_r;
  logic                   si_s;
  logic                   rx_sleep_s;
  logic                   rbusy_r;
  logic [4:0]             rcnt_r;
  logic [PAY_W-1:0]       rsh_r;
  logic [PAY_W-1:0]       pay_r;
  logic                   fr_ok_r;
  logic                   fr_bad_r;
  logic [CNT_W-1:0]       sil_r;
  logic [CNT_W-1:0]       per_r;
  logic [EV_W-1:0]        good_r;
  logic [HW-1:0]          hunt_r;
  logic [EV_W-1:0]        ev_r;
  logic [CNT_W-1:0]       div_r;
  logic                   start;
  logic                   stopped;
  logic                   rate_ok;
  logic                   run;
  logic                   rc_rise;
  logic                   rc_fall;
  logic                   out_ev;
  logic                   req;

  ecvs_sync #(.W(PIX_W+CTL_W+4)) u_tx_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .d       ({tx_pixel_clk, tx_pixel_bits, tx_control_bits, tx_pixel_valid,
                tx_train, tx_sleep_n}),
    .q       (tx_s)
  );
  ecvs_sync #(.W(2)) u_rx_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .d       ({serial_in, rx_sleep_n}),
    .q       (rx_s)
  );
  assign si_s       = rx_s[1];
  assign rx_sleep_s = rx_s[0];

  // transmitter hookup; the training input is the handshake wire or software
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pck_d_r <= 1'b0;
    end else begin
      pck_d_r <= tx_s[PIX_W+CTL_W+3];
    end
  end
  assign t.pclk_rise    = tx_s[PIX_W+CTL_W+3] & ~pck_d_r;
  assign t.pclk_fall    = ~tx_s[PIX_W+CTL_W+3] & pck_d_r;
  assign t.pixel_bits   = tx_s[PIX_W+CTL_W+2 -: PIX_W];
  assign t.control_bits = tx_s[CTL_W+2 -: CTL_W];
  assign t.pixel_valid  = tx_s[2];
  assign t.train        = tx_s[1] | ctrl_r[CB_TRAIN];
  assign t.sleep_n      = tx_s[0];
  assign t.edge_rising  = ctrl_r[CB_TX_EDGE];
  assign serial_out      = t.serial_out;
  assign serial_out_oe_n = t.serial_oe_n;
  ecvs_tx u_tx (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .t       (t.tx)
  );

  // register slave: one wait cycle per access
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ack_r        <= 1'b0;
      ctrl_r       <= CTRL_RST;
      avs_readdata <= '0;
    end else begin
      ack_r <= req & ~ack_r;
      if (avs_write && ack_r && avs_address == REG_CTRL && avs_byteenable[0]) begin
        ctrl_r <= avs_writedata[2:0];
      end
      if (avs_read && !ack_r) begin
        case (avs_address)
          REG_CTRL: avs_readdata <= {29'h0, ctrl_r};
          REG_STAT: avs_readdata <= {25'h0, st_r, t.training, rx_unlocked};
          REG_RATE: avs_readdata <= {26'h0, per_r};
          default:  avs_readdata <= '0;
        endcase
      end
    end
  end

  // frame receiver: start bit, type, payload, stop bit
  assign start = !rbusy_r && !si_s && rx_sleep_s;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rbusy_r  <= 1'b0;
      rcnt_r   <= '0;
      rsh_r    <= '0;
      pay_r    <= '0;
      fr_ok_r  <= 1'b0;
      fr_bad_r <= 1'b0;
    end else begin
      fr_ok_r  <= 1'b0;
      fr_bad_r <= 1'b0;
      if (!rx_sleep_s) begin
        rbusy_r <= 1'b0;
      end else if (start) begin
        rbusy_r <= 1'b1;
        rcnt_r  <= '0;
      end else if (rbusy_r) begin
        if (rcnt_r == 5'(PAY_W)) begin
          rbusy_r <= 1'b0;
          if (si_s && rsh_r[PAY_W-1 -: TYP_W] != '1) begin
            fr_ok_r <= 1'b1;
            pay_r   <= rsh_r;
          end else begin
            fr_bad_r <= 1'b1;
          end
        end else begin
          rsh_r  <= {rsh_r[PAY_W-2:0], si_s};
          rcnt_r <= rcnt_r + 1'b1;
        end
      end
    end
  end

  // rate detection from start-to-start spacing, silence detection
  assign rate_ok = sil_r >= CNT_W'(FRAME_LEN) && sil_r <= CNT_W'(INT_MAX);
  assign stopped = sil_r == CNT_W'(INT_MAX + STOP_CYC);
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sil_r  <= CNT_W'(INT_MAX + STOP_CYC);
      per_r  <= CNT_W'(FRAME_LEN);
      good_r <= '0;
      hunt_r <= '0;
    end else begin
      hunt_r <= (st_r == ST_HUNT) ? hunt_r + 1'b1 : '0;
      if (start) begin
        sil_r <= CNT_W'(1);
      end else if (!stopped) begin
        sil_r <= sil_r + 1'b1;
      end
      if (start && rate_ok) begin
        per_r <= sil_r;
      end
      if (st_r == ST_HUNT && hunt_r == HW'(LOCK_LIMIT - 1)) begin
        good_r <= '0;
        hunt_r <= '0;
      end else if ((start && !rate_ok) || fr_bad_r || stopped) begin
        good_r <= '0;
      end else if (fr_ok_r && good_r != EV_W'(LOCK_FRAMES)) begin
        good_r <= good_r + 1'b1;
      end
    end
  end

  // lock sequencing
  assign run = st_r == ST_LEAD || st_r == ST_LOCK || st_r == ST_TAIL;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= ST_OFF;
      ev_r <= '0;
    end else if (!rx_sleep_s) begin
      st_r <= ST_OFF;
      ev_r <= '0;
    end else begin
      if (rc_rise && ev_r != '1) begin
        ev_r <= ev_r + 1'b1;
      end
      case (st_r)
        ST_OFF: begin
          st_r <= ST_HUNT;
        end
        ST_HUNT: begin
          ev_r <= '0;
          if (good_r == EV_W'(LOCK_FRAMES)) begin
            st_r <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          if (stopped || fr_bad_r || good_r != EV_W'(LOCK_FRAMES)) begin
            st_r <= ST_HUNT;
          end else if (ev_r == EV_W'(LEAD_CYC)) begin
            st_r <= ST_LOCK;
            ev_r <= '0;
          end
        end
        ST_LOCK: begin
          if (stopped || fr_bad_r) begin
            st_r <= ST_TAIL;
            ev_r <= '0;
          end
        end
        ST_TAIL: begin
          if (rc_rise && ev_r == EV_W'(TAIL_CYC)) begin
            st_r <= ST_HUNT;
          end
        end
        default: begin
          st_r <= ST_OFF;
        end
      endcase
    end
  end
  assign rx_unlocked = st_r != ST_LOCK;

  // recovered clock: period follows measured frame spacing
  assign rc_rise = run && div_r == per_r - 1'b1;
  assign rc_fall = run && div_r == (per_r >> 1) - 1'b1;
  assign out_ev  = ctrl_r[CB_RX_EDGE] ? rc_fall : rc_rise;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      div_r           <= '0;
      recovered_clock <= 1'b0;
    end else begin
      if (!run || rc_rise) begin
        div_r <= '0;
      end else begin
        div_r <= div_r + 1'b1;
      end
      if (st_r == ST_OFF) begin
        recovered_clock <= ctrl_r[CB_RX_EDGE];
      end else if (run) begin
        recovered_clock <= rc_rise || (div_r < (per_r >> 1) - 1'b1 && !rc_fall);
      end else begin
        recovered_clock <= 1'b0;
      end
    end
  end

  // parallel outputs, zero whenever not locked
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rx_pixel_bits   <= '0;
      rx_control_bits <= '0;
      rx_pixel_valid  <= 1'b0;
    end else if (st_r != ST_LOCK) begin
      rx_pixel_bits   <= '0;
      rx_control_bits <= '0;
      rx_pixel_valid  <= 1'b0;
    end else if (out_ev && ev_r >= EV_W'(OUT_DLY)) begin
      if (pay_r[PAY_W-1 -: TYP_W] == TYP_PIX) begin
        rx_pixel_bits   <= pay_r[PIX_W-1:0];
        rx_control_bits <= '0;
        rx_pixel_valid  <= 1'b1;
      end else if (pay_r[PAY_W-1 -: TYP_W] == TYP_CTL) begin
        rx_pixel_bits   <= '0;
        rx_control_bits <= pay_r[CTL_W-1:0];
        rx_pixel_valid  <= 1'b0;
      end
    end
  end

  sequence s_lock_entry;
    st_r == ST_LEAD ##1 st_r == ST_LOCK;
  endsequence
  sequence s_tail_exit;
    st_r == ST_TAIL ##1 st_r == ST_HUNT;
  endsequence

  a_lead_ten: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_lock_entry |-> $past(ev_r) == EV_W'(LEAD_CYC)) else $error("lock too early");
  a_tail_three: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_tail_exit |-> $past(ev_r) == EV_W'(TAIL_CYC)) else $error("clock stopped early");
  a_out_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_r == ST_LOCK && ev_r < EV_W'(OUT_DLY) |=> $stable(rx_pixel_bits) && $stable(rx_pixel_valid))
    else $error("output before delay");
  a_idle_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_r != ST_LOCK |=> rx_pixel_bits == '0 && !rx_pixel_valid && rx_control_bits == '0)
    else $error("output not idle");
  a_stop_unlock: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_r == ST_LOCK && stopped |=> rx_unlocked) else $error("no unlock on stop");
  a_sleep_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !rx_sleep_s ##1 !rx_sleep_s |=> rx_unlocked && rx_pixel_bits == '0
    && recovered_clock == ctrl_r[CB_RX_EDGE]) else $error("sleep outputs");
  a_hunt_restart: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rx_sleep_s && st_r == ST_HUNT && hunt_r == HW'(LOCK_LIMIT - 1) |=> good_r == '0)
    else $error("watchdog missed");
  a_lock_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(rx_unlocked) |-> $past(good_r) == EV_W'(LOCK_FRAMES) && $past(st_r) == ST_LEAD)
    else $error("lock without good frames");
  a_avs_one_wait: assert property (@(posedge clk_sys) disable iff (sys_rst)
    req && avs_waitrequest |=> !avs_waitrequest) else $error("bus wait too long");
endmodule

// file: sim/ecvs_far_end.sv
// far-end model: serializer feeding the block and deserializer of its output
`timescale 1ns/1ps
module ecvs_far_end (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       sys_rst,
  // serial lines
  input  wire logic                       line_in,
  input  wire logic                       line_oe_n,
  output logic                            line_out,
  // word to send, spacing, last word taken
  input  wire logic                       send_en,
  input  wire logic [5:0]                 gap,
  input  wire logic [ecvs_pkg::PAY_W-1:0] send_word,
  output logic      [ecvs_pkg::PAY_W-1:0] got_word
);
  import ecvs_pkg::*;
  logic [FRAME_LEN-1:0] tx_sr;
  logic [PAY_W-1:0]     rx_sr;
  int                   tx_n;
  int                   rx_n;
  logic                 lvl;
  // a released line is pulled high
  assign lvl      = line_oe_n | line_in;
  assign line_out = tx_sr[FRAME_LEN-1];
  // start 0, type, data, stop 1, msb first, idle high between frames
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tx_n  <= 0;
      tx_sr <= '1;
    end else begin
      tx_n  <= (tx_n >= int'(gap) - 1) ? 0 : tx_n + 1;
      tx_sr <= (send_en && tx_n == 0) ? {1'b0, send_word, 1'b1} : {tx_sr[FRAME_LEN-2:0], 1'b1};
    end
  end
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rx_n     <= 0;
      got_word <= '1;
    end else if (rx_n == 0) begin
      rx_n <= lvl ? 0 : 1;
    end else begin
      rx_sr <= {rx_sr[PAY_W-2:0], lvl};
      rx_n  <= (rx_n == FRAME_LEN - 1) ? 0 : rx_n + 1;
      if (rx_n == FRAME_LEN - 1 && lvl) begin
        got_word <= rx_sr;
      end
    end
  end
endmodule

// file: sim/ecvs_top_tb.sv
// self-checking bench of the embedded-clock video link
`timescale 1ns/1ps
module ecvs_top_tb;
  import ecvs_pkg::*;
  logic             clk_sys = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0]       avs_address = 4'h0, avs_byteenable = 4'hF;
  logic [31:0]      avs_writedata = 32'h0, avs_readdata, rd;
  logic             tx_pixel_clk, tx_pixel_valid = 1'b1, tx_train = 1'b0;
  logic             tx_sleep_n = 1'b1, rx_sleep_n = 1'b1, send_en = 1'b0;
  logic [PIX_W-1:0] tx_pixel_bits = 18'h0, rx_pixel_bits, pa, pb;
  logic [CTL_W-1:0] tx_control_bits = 3'h0, rx_control_bits;
  logic             avs_waitrequest, serial_out, serial_out_oe_n, serial_in;
  logic             rx_pixel_valid, rx_unlocked, recovered_clock, rc_d;
  logic [5:0]       gap = 6'h16;
  logic [PAY_W-1:0] send_word = 20'h0, got_word;
  int               num_errors = 0, tests_run = 0, cycles = 0, seed = 86, rises = 0, i, e, r0;

  ecvs_top #(.LOCK_LIMIT(2000)) i_dut (.*);
  ecvs_far_end i_far (.clk_sys(clk_sys), .sys_rst(sys_rst), .line_in(serial_out),
    .line_oe_n(serial_out_oe_n), .line_out(serial_in), .send_en(send_en), .gap(gap),
    .send_word(send_word), .got_word(got_word));

  always #12.5 clk_sys = ~clk_sys;
  initial begin
    tx_pixel_clk = 1'b0;
    #7;
    forever #100 tx_pixel_clk = ~tx_pixel_clk;
  end
  always @(posedge clk_sys) begin
    rc_d <= recovered_clock;
    if (recovered_clock === 1'b1 && rc_d === 1'b0) rises <= rises + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      $display("mismatch at %0t: run did not finish", $time);
      test_done();
    end
  end

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic check_frame(input logic [PAY_W-1:0] exp);
    check_val(32'(got_word), 32'(exp));
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     input logic [3:0] be);
    @(posedge clk_sys);
    avs_read       <= !wr;
    avs_write      <= wr;
    avs_address    <= a;
    avs_writedata  <= wd;
    avs_byteenable <= be;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hF);
    check_val(rd, exp);
  endtask
  task automatic tx_word(input logic v);
    @(posedge clk_sys);
    tx_pixel_valid  <= v;
    tx_pixel_bits   <= PIX_W'($random(seed));
    tx_control_bits <= CTL_W'($random(seed));
    repeat (v ? 90 : 420) @(posedge clk_sys);
    check_frame(v ? {TYP_PIX, tx_pixel_bits} : {TYP_CTL, 15'h0, tx_control_bits});
  endtask
  task automatic lock_up(input logic [5:0] g);
    int k;
    gap     <= g;
    send_en <= 1'b1;
    r0 = rises;
    for (k = 0; k < 2000 && rx_unlocked !== 1'b0; k++) @(posedge clk_sys);
    check_val(rx_unlocked, 1'b0);
    check_val(32'(rises - r0 >= 10), 32'h1);
    check_val(rx_pixel_bits, 18'h0);
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd_chk(REG_CTRL, 32'h1);
    rd_chk(REG_RATE, 32'h16);
    rd_chk(REG_STAT, 32'h9);
    rd_chk(4'hC, 32'h0);
    bus(1'b1, REG_CTRL, 32'h6, 4'h0);
    rd_chk(REG_CTRL, 32'h1);
    $display("test registers done");
    for (e = 1; e >= 0; e--) begin
      bus(1'b1, REG_CTRL, 32'(e), 4'h1);
      rd_chk(REG_CTRL, 32'(e));
      for (i = 0; i < 4; i++) tx_word(i[0]);
      pa = PIX_W'($random(seed));
      pb = ~pa;
      // data differs between the two pixel clock phases
      repeat (40) begin
        @(posedge tx_pixel_clk);
        @(posedge clk_sys);
        tx_pixel_bits <= pb;
        @(negedge tx_pixel_clk);
        @(posedge clk_sys);
        tx_pixel_bits <= pa;
      end
      check_frame({TYP_PIX, e ? pa : pb});
    end
    $display("test transmit words done");
    tx_train <= 1'b1;
    repeat (100) @(posedge clk_sys);
    check_frame({TYP_TRN, TRN_DATA});
    tx_train <= 1'b0;
    repeat (1000) @(posedge tx_pixel_clk);
    repeat (30) @(posedge clk_sys);
    check_frame({TYP_TRN, TRN_DATA});
    rd_chk(REG_STAT, 32'hB);
    repeat (40) @(posedge tx_pixel_clk);
    repeat (30) @(posedge clk_sys);
    check_frame({TYP_PIX, tx_pixel_bits});
    tx_sleep_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    check_val(serial_out_oe_n, 1'b1);
    tx_sleep_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check_val(serial_out_oe_n, 1'b0);
    $display("test training and sleep done");
    send_word <= {TYP_PIX, PIX_W'($random(seed))};
    lock_up(6'd22);
    for (i = 0; i < 4; i++) begin
      send_word <= i[0] ? {TYP_CTL, 15'h0, CTL_W'($random(seed))} : {TYP_PIX, PIX_W'($random(seed))};
      repeat (100) @(posedge clk_sys);
      if (i[0]) check_val({rx_pixel_valid, rx_control_bits}, {1'b0, send_word[CTL_W-1:0]});
      else check_val({rx_pixel_valid, rx_pixel_bits}, {1'b1, send_word[PIX_W-1:0]});
    end
    send_en <= 1'b0;
    for (i = 0; i < 60 && rx_unlocked !== 1'b1; i++) @(posedge clk_sys);
    check_val(rx_unlocked, 1'b1);
    r0 = rises;
    repeat (150) @(posedge clk_sys);
    check_val(32'(rises - r0 >= 3), 32'h1);
    check_val({rx_pixel_valid, rx_pixel_bits, recovered_clock}, 20'h0);
    lock_up(6'd30);
    rx_sleep_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    check_val({rx_unlocked, rx_pixel_valid, rx_pixel_bits, rx_control_bits, recovered_clock},
              {1'b1, 23'h0});
    $display("test receive done");
    test_done();
  end
endmodule
